// ### hw/dev_cmd_interp.sv
// Device end: command interpreter, register guard and config checksum.
// Assumes the host end drives the link and obeys its own framing.
`timescale 1ns/1ps
`include "hcr_params.svh"
module dev_cmd_interp
  import hcr_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Serial link
  host_link_if.dev         link,
  // Calculation engine writes and rate tick
  input  wire logic        eng_wr_en,
  input  wire logic [1:0]  eng_wr_idx,
  input  wire logic [23:0] eng_wr_data,
  input  wire logic        low_rate_tick,
  // Instruction outputs
  output logic             instr_valid,
  output logic [5:0]       instr_code,
  output cal_type_t        cal_type,
  output logic [2:0]       cal_chan,
  output logic             instr_invalid,
  // Guard state
  output logic             eng_locked,
  output logic             host_locked,
  output logic [23:0]      csum_result,
  output logic             rx_csum_error
);
  dev_state_t  state_reg;
  logic [7:0]  cmd_reg;
  logic [23:0] data_reg;
  logic [1:0]  cnt_reg;
  logic [5:0]  page_reg;
  logic [24:0] idle_reg;
  logic [23:0] serial_ctrl_reg;
  logic [23:0] status_reg;
  logic [23:0] lock_reg;
  logic        eng_lock_reg;
  logic        host_lock_reg;
  logic [23:0] cfg_reg [`CFG_WORDS];
  logic [23:0] chk_reg;
  logic [23:0] chk_next;
  logic        ivalid_reg;
  logic [5:0]  icode_reg;
  logic        iinv_reg;
  logic [7:0]  out_reg;
  logic        out_valid_reg;
  logic [23:0] tx_reg;
  logic [7:0]  rx_sum;
  logic [7:0]  tx_sum;
  logic        rx;
  logic        csum_en;
  logic [11:0] addr;
  logic        wr_go;
  logic        err_set;
  logic        tx_add;

  // ================================================================
  // Address decode shared by reads and writes
  function automatic logic [2:0] cfg_hit(input logic [11:0] a);
    cfg_hit = {(a >= `ADDR_CFG_BASE) && (a < `ADDR_CFG_BASE + 12'(`CFG_WORDS)),
               2'(a - `ADDR_CFG_BASE)};
  endfunction

  assign rx      = link.host_input_valid;
  assign csum_en = serial_ctrl_reg[`CSUM_EN_BIT];
  assign addr    = {page_reg, cmd_reg[5:0]};
  assign wr_go   = (state_reg == DS_EXEC) && (cmd_reg[7:6] == CMD_WRITE);
  assign err_set = (state_reg == DS_CSUM) && rx && (link.host_input_line != rx_sum);
  assign tx_add  = (state_reg == DS_TX) && (cnt_reg != 2'd3);

  chk_accum u_rx_sum (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (state_reg == DS_CMD),
    .add      (rx && (state_reg == DS_CMD || state_reg == DS_DATA)),
    .data     (link.host_input_line),
    .sum_reg  (rx_sum)
  );

  chk_accum u_tx_sum (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (state_reg == DS_EXEC),
    .add      (tx_add),
    .data     (tx_reg[23:16]),
    .sum_reg  (tx_sum)
  );

  // ================================================================
  // Frame sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DS_CMD;
      cmd_reg   <= 8'h00;
      data_reg  <= 24'h000000;
      cnt_reg   <= 2'd0;
    end else begin
      case (state_reg)
        DS_CMD: begin
          if (rx) begin
            cmd_reg <= link.host_input_line;
            cnt_reg <= 2'd0;
            if (link.host_input_line[7:6] == CMD_WRITE) begin
              state_reg <= DS_DATA;
            end else begin
              state_reg <= csum_en ? DS_CSUM : DS_EXEC;
            end
          end
        end
        DS_DATA: begin
          if (idle_reg == 25'(TIMEOUT_CYCLES - 1)) begin
            state_reg <= DS_CMD;
          end else if (rx) begin
            data_reg <= {data_reg[15:0], link.host_input_line};
            cnt_reg  <= cnt_reg + 2'd1;
            if (cnt_reg == 2'd2) begin
              state_reg <= csum_en ? DS_CSUM : DS_EXEC;
            end
          end
        end
        DS_CSUM: begin
          if (idle_reg == 25'(TIMEOUT_CYCLES - 1)) begin
            state_reg <= DS_CMD;
          end else if (rx) begin
            state_reg <= err_set ? DS_CMD : DS_EXEC;
          end
        end
        DS_EXEC: begin
          cnt_reg   <= 2'd0;
          state_reg <= (cmd_reg[7:6] == CMD_READ) ? DS_TX : DS_CMD;
        end
        DS_TX: begin
          cnt_reg <= cnt_reg + 2'd1;
          if (cnt_reg == (csum_en ? 2'd3 : 2'd2)) begin
            state_reg <= DS_CMD;
          end
        end
        default: begin
          state_reg <= DS_CMD;
        end
      endcase
    end
  end

  // Gap timer runs only inside a started frame.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_reg <= 25'd0;
    end else if (rx || !(state_reg == DS_DATA || state_reg == DS_CSUM)) begin
      idle_reg <= 25'd0;
    end else begin
      idle_reg <= idle_reg + 25'd1;
    end
  end

  // ================================================================
  // Page, lock and serial control registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_reg <= 6'h00;
    end else if (state_reg == DS_EXEC && cmd_reg[7:6] == CMD_PAGE) begin
      page_reg <= cmd_reg[5:0];
    end
  end

  // The lock register itself is never locked, or a lock could not be undone.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg      <= `LOCK_RST;
      eng_lock_reg  <= 1'b0;
      host_lock_reg <= 1'b0;
    end else if (wr_go && addr == `ADDR_LOCK) begin
      lock_reg <= data_reg;
      if (data_reg[`ENG_KEY_LSB +: 5] == `KEY_LOCK) begin
        eng_lock_reg <= 1'b1;
      end else if (data_reg[`ENG_KEY_LSB +: 5] == `KEY_UNLOCK) begin
        eng_lock_reg <= 1'b0;
      end
      if (data_reg[`HOST_KEY_LSB +: 5] == `KEY_LOCK) begin
        host_lock_reg <= 1'b1;
      end else if (data_reg[`HOST_KEY_LSB +: 5] == `KEY_UNLOCK) begin
        host_lock_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_ctrl_reg <= `SERIAL_CTRL_RST;
    end else if (wr_go && addr == `ADDR_SERIAL_CTRL && !host_lock_reg) begin
      serial_ctrl_reg <= data_reg;
    end
  end

  // A new error wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= `STATUS_RST;
    end else if (err_set) begin
      status_reg[`RECEIVE_CHECKSUM_ERROR_BIT] <= 1'b1;
    end else if (wr_go && addr == `ADDR_STATUS && data_reg[`RECEIVE_CHECKSUM_ERROR_BIT]) begin
      status_reg[`RECEIVE_CHECKSUM_ERROR_BIT] <= 1'b0;
    end
  end

  // ================================================================
  // Protected configuration words; host write takes the cycle over the engine
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_WORDS; gi++) begin : g_cfg
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          cfg_reg[gi] <= 24'h000000;
        end else if (wr_go && cfg_hit(addr) == {1'b1, 2'(gi)}) begin
          if (!host_lock_reg) begin
            cfg_reg[gi] <= data_reg;
          end
        end else if (eng_wr_en && eng_wr_idx == 2'(gi) && !eng_lock_reg) begin
          cfg_reg[gi] <= eng_wr_data;
        end
      end
    end
  endgenerate

  always_comb begin
    chk_next = serial_ctrl_reg;
    for (int i = 0; i < `CFG_WORDS; i++) begin
      chk_next = chk_next + cfg_reg[i];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_reg <= 24'h000000;
    end else if (low_rate_tick && !cfg_reg[0][`CSUM_OFF_BIT]) begin
      chk_reg <= ~chk_next;
    end
  end

  // ================================================================
  // Instruction decode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ivalid_reg <= 1'b0;
      icode_reg  <= 6'h00;
      iinv_reg   <= 1'b0;
    end else begin
      ivalid_reg <= (state_reg == DS_EXEC) && (cmd_reg[7:6] == CMD_INSTR);
      if (state_reg == DS_EXEC && cmd_reg[7:6] == CMD_INSTR) begin
        icode_reg <= cmd_reg[5:0];
        if (!cmd_reg[5]) begin
          case (cmd_reg[4:0])
            5'h01, 5'h02, 5'h03, 5'h14, 5'h15, 5'h18: iinv_reg <= 1'b0;
            default: iinv_reg <= 1'b1;
          endcase
        end else begin
          iinv_reg <= (cmd_reg[4:3] == CAL_RSVD)
            || (cmd_reg[2:0] == 3'b000) || (cmd_reg[2:0] == 3'b101)
            || (cmd_reg[2:0] == 3'b111)
            || (cmd_reg[4:3] == CAL_AC && !cmd_reg[0] && cmd_reg[2:0] != 3'b110);
        end
      end
    end
  end

  // ================================================================
  // Read answer: three data bytes, then the checksum byte when enabled
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg        <= 24'h000000;
      out_reg       <= 8'h00;
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= (state_reg == DS_TX);
      if (state_reg == DS_EXEC) begin
        if (addr == `ADDR_SERIAL_CTRL) begin
          tx_reg <= serial_ctrl_reg;
        end else if (addr == `ADDR_STATUS) begin
          tx_reg <= status_reg;
        end else if (addr == `ADDR_LOCK) begin
          tx_reg <= lock_reg;
        end else if (addr == `ADDR_CHK) begin
          tx_reg <= chk_reg;
        end else if (cfg_hit(addr)[2]) begin
          tx_reg <= cfg_reg[cfg_hit(addr)[1:0]];
        end else begin
          tx_reg <= 24'h000000;
        end
      end else if (state_reg == DS_TX) begin
        out_reg <= (cnt_reg == 2'd3) ? tx_sum : tx_reg[23:16];
        tx_reg  <= {tx_reg[15:0], 8'h00};
      end
    end
  end

  assign link.host_output_line  = out_reg;
  assign link.host_output_valid = out_valid_reg;
  assign instr_valid   = ivalid_reg;
  assign instr_code    = icode_reg;
  assign cal_type      = cal_type_t'(icode_reg[4:3]);
  assign cal_chan      = icode_reg[2:0];
  assign instr_invalid = iinv_reg;
  assign eng_locked    = eng_lock_reg;
  assign host_locked   = host_lock_reg;
  assign csum_result   = chk_reg;
  assign rx_csum_error = status_reg[`RECEIVE_CHECKSUM_ERROR_BIT];
endmodule // dev_cmd_interp

// ### shared/hcr_params.svh
// Constants for the host command interpreter and its register guard.
// Assumes a 250 MHz core clock shared by both ends of the byte link.
`ifndef HCR_PARAMS_SVH
`define HCR_PARAMS_SVH

// ==================================================================
// Lock keys and field positions
`define KEY_LOCK          5'h16
`define KEY_UNLOCK        5'h09
`define ENG_KEY_LSB       0
`define HOST_KEY_LSB      8

// ==================================================================
// Twelve-bit register addresses {page, address}
`define ADDR_SERIAL_CTRL  12'h007
`define ADDR_STATUS       12'h017
`define ADDR_LOCK         12'h022
`define ADDR_CFG_BASE     12'h400
`define ADDR_CHK          12'h404
`define CFG_WORDS         4

// ==================================================================
// Reset values and bit positions
`define SERIAL_CTRL_RST   24'h02004D
`define STATUS_RST        24'h800000
`define LOCK_RST          24'h000000
`define CSUM_EN_BIT       18
`define RECEIVE_CHECKSUM_ERROR_BIT   17
`define CSUM_OFF_BIT      0
`define CSUM_SEED         8'hFF

// ==================================================================
// Timing
`define CLK_HZ            250000000
`define TIMEOUT_MS        128
`define TIMEOUT_CYCLES    (`TIMEOUT_MS * (`CLK_HZ / 1000))

`endif

// ### shared/hcr_pkg.sv
// Types shared by both ends of the host command link.
// Assumes hcr_params.svh supplies the numeric constants.
package hcr_pkg;

  // ================================================================
  // Command kinds, operations and states
  typedef enum logic [1:0] {
    CMD_READ  = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_PAGE  = 2'b10,
    CMD_INSTR = 2'b11
  } cmd_kind_t;

  typedef enum logic [1:0] {
    CAL_DC   = 2'b00,
    CAL_RSVD = 2'b01,
    CAL_AC   = 2'b10,
    CAL_GAIN = 2'b11
  } cal_type_t;

  typedef enum logic [2:0] {
    DS_CMD  = 3'b000,
    DS_DATA = 3'b001,
    DS_CSUM = 3'b010,
    DS_EXEC = 3'b011,
    DS_TX   = 3'b100
  } dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_RECV = 2'b10
  } host_state_t;

endpackage

// ### shared/host_link_if.sv
// Byte link between the host controller end and the device end.
// Assumes one byte per valid cycle on each direction, both on core_clk.
`timescale 1ns/1ps
interface host_link_if;
  logic [7:0] host_input_line;
  logic       host_input_valid;
  logic [7:0] host_output_line;
  logic       host_output_valid;

  modport dev (
    input  host_input_line,
    input  host_input_valid,
    output host_output_line,
    output host_output_valid
  );

  modport host (
    output host_input_line,
    output host_input_valid,
    input  host_output_line,
    input  host_output_valid
  );
endinterface

// ### hw/chk_accum.sv
// Running serial checksum: seed minus every byte added, modulo 256.
// Assumes clr is raised with or before the first byte of a frame.
`timescale 1ns/1ps
`include "hcr_params.svh"
module chk_accum (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Byte stream
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] data,
  output logic      [7:0] sum_reg
);
  // ================================================================
  // Accumulator
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_reg <= `CSUM_SEED;
    end else if (add) begin
      sum_reg <= (clr ? `CSUM_SEED : sum_reg) - data;
    end else if (clr) begin
      sum_reg <= `CSUM_SEED;
    end
  end
endmodule // chk_accum

// ### hw/host_cmd_master.sv
// Host end: frames commands onto the byte link and collects read answers.
// Assumes the device end answers every read on the same clock; HS_RECV waits for it with no limit.
`timescale 1ns/1ps
module host_cmd_master
  import hcr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Serial link
  host_link_if.host        link,
  // Command request
  input  wire logic        cmd_valid,
  input  wire cmd_kind_t   cmd_kind,
  input  wire logic [5:0]  cmd_arg,
  input  wire logic [23:0] cmd_data,
  input  wire logic        csum_en,
  input  wire logic        chk_save,
  input  wire logic        chk_check,
  output logic             cmd_ready,
  // Read answer
  output logic             rd_valid,
  output logic [23:0]      rd_data,
  output logic             rd_csum_bad,
  output logic             reload_req
);
  host_state_t state_reg;
  logic [7:0]  cmd_reg;
  logic [23:0] data_reg;
  logic [2:0]  cnt_reg;
  logic [2:0]  last;
  logic        save_reg;
  logic        check_reg;
  logic [23:0] saved_reg;
  logic        reload_reg;
  logic        rd_valid_reg;
  logic        bad_reg;
  logic [7:0]  out_reg;
  logic        out_valid_reg;
  logic [7:0]  tx_sum;
  logic [7:0]  rx_sum;
  logic        rx;

  assign rx   = link.host_output_valid;
  assign last = 3'((cmd_reg[7:6] == CMD_WRITE) ? 3 : 0) + (csum_en ? 3'd1 : 3'd0);

  chk_accum u_tx_sum (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (state_reg == HS_IDLE),
    .add      (state_reg == HS_SEND && !(csum_en && cnt_reg == last)),
    .data     (out_reg),
    .sum_reg  (tx_sum)
  );

  chk_accum u_rx_sum (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (state_reg == HS_SEND),
    .add      (rx && state_reg == HS_RECV && cnt_reg != 3'd3),
    .data     (link.host_output_line),
    .sum_reg  (rx_sum)
  );

  // ================================================================
  // Byte sequencer; bytes leave back to back, well inside the gap limit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= HS_IDLE;
      cmd_reg       <= 8'h00;
      data_reg      <= 24'h000000;
      cnt_reg       <= 3'd0;
      out_reg       <= 8'h00;
      out_valid_reg <= 1'b0;
      rd_valid_reg  <= 1'b0;
      bad_reg       <= 1'b0;
    end else begin
      out_valid_reg <= 1'b0;
      rd_valid_reg  <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          if (cmd_valid) begin
            cmd_reg       <= {cmd_kind, cmd_arg};
            data_reg      <= cmd_data;
            out_reg       <= {cmd_kind, cmd_arg};
            out_valid_reg <= 1'b1;
            cnt_reg       <= 3'd0;
            state_reg     <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (cnt_reg == last) begin
            cnt_reg   <= 3'd0;
            state_reg <= (cmd_reg[7:6] == CMD_READ) ? HS_RECV : HS_IDLE;
          end else begin
            out_valid_reg <= 1'b1;
            cnt_reg       <= cnt_reg + 3'd1;
            if (csum_en && cnt_reg + 3'd1 == last) begin
              out_reg <= tx_sum - out_reg;
            end else begin
              out_reg  <= data_reg[23:16];
              data_reg <= {data_reg[15:0], 8'h00};
            end
          end
        end
        HS_RECV: begin
          if (rx) begin
            cnt_reg <= cnt_reg + 3'd1;
            if (cnt_reg == 3'd3) begin
              bad_reg      <= (link.host_output_line != rx_sum);
              rd_valid_reg <= 1'b1;
              state_reg    <= HS_IDLE;
            end else begin
              data_reg <= {data_reg[15:0], link.host_output_line};
              if (cnt_reg == 3'd2 && !csum_en) begin
                bad_reg      <= 1'b0;
                rd_valid_reg <= 1'b1;
                state_reg    <= HS_IDLE;
              end
            end
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  // ================================================================
  // Configuration checksum watch: save once, compare on later reads
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      save_reg   <= 1'b0;
      check_reg  <= 1'b0;
      saved_reg  <= 24'h000000;
      reload_reg <= 1'b0;
    end else if (rd_valid_reg) begin
      save_reg  <= 1'b0;
      check_reg <= 1'b0;
      if (save_reg) begin
        saved_reg <= data_reg;
      end
      if (check_reg) begin
        reload_reg <= (data_reg != saved_reg);
      end
    end else if (state_reg == HS_IDLE && cmd_valid) begin
      save_reg  <= chk_save;
      check_reg <= chk_check;
    end
  end

  assign link.host_input_line  = out_reg;
  assign link.host_input_valid = out_valid_reg;
  assign cmd_ready   = (state_reg == HS_IDLE);
  assign rd_valid    = rd_valid_reg;
  assign rd_data     = data_reg;
  assign rd_csum_bad = bad_reg;
  assign reload_req  = reload_reg;
endmodule // host_cmd_master

// ### sim/hcr_link_chk.sv
// Checker for the byte link between the host end and the device end.
// Assumes both ends run on core_clk and frames are split by idle cycles.
`timescale 1ns/1ps
module hcr_link_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Byte link
  input wire logic [7:0] host_input_line,
  input wire logic       host_input_valid,
  input wire logic [7:0] host_output_line,
  input wire logic       host_output_valid
);
  // ==============================================================
  // Link checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire       iv = host_input_valid;
  wire       ov = host_output_valid;
  wire [1:0] k  = host_input_line[7:6];
  out_burst_a: assert property ($rose(ov) |-> ov[*3]) else $error("short answer");
  burst_max_a: assert property (ov[*4] |=> !ov) else $error("long answer");
  no_overlap_a: assert property (ov |-> !iv) else $error("link overlap");
  read_answer_a: assert property ($rose(iv) && k == 2'h0 |-> ##[2:6] $rose(ov))
    else $error("no answer");
  read_gap_a: assert property ($rose(iv) && k == 2'h0 |-> ##2 !iv) else $error("gap");
  write_frame_a: assert property ($rose(iv) && k == 2'h1 |-> iv[*4])
    else $error("write frame short");
  ctrl_silent_a: assert property ($rose(iv) && k[1] |=> !ov[*3]) else $error("answer");
  answer_sum_a: assert property (ov[*4] |-> host_output_line == 8'hFF
    - $past(host_output_line, 1) - $past(host_output_line, 2) - $past(host_output_line, 3))
    else $error("answer checksum");
  cover property ($rose(iv) && k == 2'h0);
  cover property ($rose(iv) && k == 2'h1);
  cover property (ov[*4]);
endmodule // hcr_link_chk

// ### sim/host_command_register_guard_tb_top.sv
// Testbench joining the host end and the device end over the byte link.
// Assumes the shared package and both design ends are compiled first.
`timescale 1ns/1ps
module host_command_register_guard_tb_top;
  import hcr_pkg::*;
  // ==============================================================
  // Signals
  logic        core_clk = 0, arst_n = 0, cmd_valid = 0, csum_en = 0, chk_save = 0;
  logic        chk_check = 0, eng_wr_en = 0, low_rate_tick = 0;
  cmd_kind_t   cmd_kind = CMD_READ;
  logic [5:0]  cmd_arg = '0, instr_code;
  logic [1:0]  eng_wr_idx = '0;
  logic [23:0] cmd_data = '0, eng_wr_data = '0, rd_data, csum_result, cfg [4], r;
  logic [23:0] sc = 24'h02004D, q_rd [$];
  logic        cmd_ready, rd_valid, rd_csum_bad, reload_req, instr_valid;
  logic        instr_invalid, eng_locked, host_locked, rx_csum_error;
  cal_type_t   cal_type;
  logic [2:0]  cal_chan;
  logic [11:0] q_in [$];
  logic [31:0] seed = 32'h16;
  int          num_errors = 0, n_tests = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  host_link_if host_link_if_inst ();
  dev_cmd_interp #(.TIMEOUT_CYCLES(50)) dev_cmd_interp_inst (.core_clk, .arst_n,
    .link(host_link_if_inst), .eng_wr_en, .eng_wr_idx, .eng_wr_data, .low_rate_tick,
    .instr_valid, .instr_code, .cal_type, .cal_chan, .instr_invalid, .eng_locked,
    .host_locked, .csum_result, .rx_csum_error);
  host_cmd_master host_cmd_master_inst (.core_clk, .arst_n, .link(host_link_if_inst),
    .cmd_valid, .cmd_kind, .cmd_arg, .cmd_data, .csum_en, .chk_save, .chk_check,
    .cmd_ready, .rd_valid, .rd_data, .rd_csum_bad, .reload_req);
  hcr_link_chk hcr_link_chk_inst (.core_clk, .arst_n,
    .host_input_line(host_link_if_inst.host_input_line),
    .host_input_valid(host_link_if_inst.host_input_valid),
    .host_output_line(host_link_if_inst.host_output_line),
    .host_output_valid(host_link_if_inst.host_output_valid));
  // ==============================================================
  // Helpers
  function automatic logic [23:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction
  function automatic logic [23:0] csum();
    return ~(sc + cfg[0] + cfg[1] + cfg[2] + cfg[3]);
  endfunction
  function automatic logic [11:0] ins(logic [5:0] c);
    logic ok;
    if (!c[5]) ok = c[4:0] inside {5'h01, 5'h02, 5'h03, 5'h14, 5'h15, 5'h18};
    else ok = c[4:3] != 2'h1 && c[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6}
              && !(c[4:3] == 2'h2 && c[2:0] inside {3'h2, 3'h4});
    return {!ok, c[4:3], c[2:0], c};
  endfunction
  task automatic chk(logic [23:0] g, logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The request is held over the edge that sees ready high, and the call returns
  // only once the host end is idle, so csum_en never moves inside a frame.
  task automatic send(cmd_kind_t k, logic [5:0] a, logic [23:0] d = '0);
    @(negedge core_clk);
    cmd_kind = k;
    {cmd_arg, cmd_data, cmd_valid} = {a, d, 1'b1};
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    {cmd_valid, chk_save, chk_check} = '0;
    while (cmd_ready !== 1'b1) @(negedge core_clk);
  endtask
  task automatic wr(logic [11:0] a, logic [23:0] d);
    send(CMD_PAGE, a[11:6]);
    send(CMD_WRITE, a[5:0], d);
  endtask
  task automatic rd(logic [11:0] a, logic [23:0] e, logic [1:0] f = '0);
    send(CMD_PAGE, a[11:6]);
    q_rd.push_back(e);
    {chk_save, chk_check} = f;
    send(CMD_READ, a[5:0]);
  endtask
  task automatic eng(logic [1:0] i, logic [23:0] d, logic t);
    @(negedge core_clk);
    {eng_wr_en, low_rate_tick, eng_wr_idx, eng_wr_data} = {!t, t, i, d};
    @(negedge core_clk);
    {eng_wr_en, low_rate_tick} = '0;
  endtask
  task automatic drain;
    while (q_rd.size() != 0) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
  endtask
  // ==============================================================
  // Checking and stimulus
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) chk(rd_data, q_rd.pop_front());
    if (instr_valid === 1'b1)
      chk({instr_invalid, cal_type, cal_chan, instr_code}, q_in.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1;
    rd(12'h007, sc);
    rd(12'h017, 24'h800000);
    for (int i = 0; i < 4; i++) begin
      cfg[i] = rnd() & 24'hFFFFFE;
      wr(12'h400 + 12'(i), cfg[i]);
      rd(12'h400 + 12'(i), cfg[i]);
    end
    q_rd.push_back(cfg[1]);
    send(CMD_READ, 6'h01);
    rd(12'h001, 24'h000000);
    wr(12'h022, 24'h000016);
    eng(2'h2, ~cfg[2], 0);
    chk(eng_locked, 1);
    rd(12'h402, cfg[2]);
    wr(12'h022, 24'h001609);
    wr(12'h401, ~cfg[1]);
    rd(12'h401, cfg[1]);
    chk(host_locked, 1);
    cfg[2] = rnd();
    eng(2'h2, cfg[2], 0);
    rd(12'h402, cfg[2]);
    wr(12'h022, 24'h000900);
    eng(2'h0, '0, 1);
    chk({eng_locked, host_locked}, 0);
    rd(12'h404, csum(), 2'h2);
    cfg[3] = rnd();
    wr(12'h403, cfg[3]);
    eng(2'h0, '0, 1);
    rd(12'h404, csum(), 2'h1);
    drain;
    chk(reload_req, 1);
    r = csum();
    cfg[0] = 24'h000001;
    wr(12'h400, cfg[0]);
    eng(2'h0, '0, 1);
    rd(12'h404, r);
    chk(csum_result, r);
    for (int c = 0; c < 64; c++) begin
      q_in.push_back(ins(6'(c)));
      send(CMD_INSTR, 6'(c));
    end
    sc[18] = 1;
    wr(12'h007, sc);
    csum_en = 1;
    rd(12'h007, sc);
    drain;
    chk(rd_csum_bad, 0);
    csum_en = 0;
    send(CMD_PAGE, 6'h10);
    send(CMD_PAGE, 6'h10);
    csum_en = 1;
    q_rd.push_back(24'h820000);
    send(CMD_READ, 6'h17);
    drain;
    chk(rx_csum_error, 1);
    wr(12'h017, 24'h020000);
    rd(12'h017, 24'h800000);
    drain;
    chk(rx_csum_error, 0);
    send(CMD_PAGE, 6'h10);
    csum_en = 0;
    send(CMD_WRITE, 6'h03, ~cfg[3]);
    repeat (60) @(negedge core_clk);
    csum_en = 1;
    rd(12'h403, cfg[3]);
    rd(12'h017, 24'h800000);
    drain;
    chk(24'(q_in.size()), 0);
    stop_test;
  end
endmodule // host_command_register_guard_tb_top
